/* File: hdl/pushbutton_reset_controller.v */
// Push-button wake/restart supervisor with register port and interrupt.
// Assumes single 50 MHz clock, button pin synchronised here, supply
// status levels from analog comparators (also synchronised here).
//
// Contract
// - Button input pulled up, idle reads released
// - Act only with battery or valid charging input
// - Separate hold selections for wake and restart
// - Wake gives 128 us pulse, sets flags
// - Flags stay until control register read
// - Restart gives interrupt pulse and restart output
// - One restart pulse per qualifying hold
// - Re-arm needs release then a new restart hold
// - Battery only restart enters ship or high-z
// - With input supply, resume previous state
// - Re-enable disabled system rail on high-z/active
// - Restart optionally needs valid input window
`timescale 1ns/100ps
`default_nettype none
`include "pb_reset_map.vh"

module pushbutton_reset_controller #(
   parameter [15:0] MS_CYCLES = (`CLK_MHZ * `US_PER_MS),
   parameter [31:0] INT_CYC   = (`INT_PULSE_US * `CLK_MHZ),
   parameter [31:0] RST_CYC   = (`RESTART_PULSE_MS * MS_CYCLES)
) (
   input  wire       CLK,
   input  wire       RST_N,
   input  wire       CLK_EN,
   input  wire       MANUAL_BUTTON_N,
   output wire       BUTTON_PULLUP_EN,
   input  wire       BATTERY_PRESENT,
   input  wire       INPUT_SUPPLY_VALID,
   input  wire       INPUT_SUPPLY_IN_WINDOW,
   input  wire       CHARGE_ENABLED,
   input  wire       SYSTEM_RAIL_WAS_ON,
   input  wire [3:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR,
   input  wire       RD,
   output reg  [7:0] RDATA,
   output reg        INT_PULSE_N,
   output reg        RESTART_N,
   output reg  [1:0] RECOVERY_STATE,
   output reg        RECOVERY_VALID,
   output reg        SYSTEM_RAIL_REENABLE,
   output wire       IRQ
);
   localparam ST_IDLE = 2'h0;
   localparam ST_HELD = 2'h1;
   localparam ST_WAIT = 2'h2;

   // Pull-up is a static analog enable; idle input reads released
   assign BUTTON_PULLUP_EN = 1'b1;

   // All pin and comparator levels are asynchronous to CLK
   wire [4:0] lvl_s;
   wire       bat_ok;

   // Chains rest at released/valid so reset shows no false press
   pin_sync #(
      .WIDTH     (5),
      .RESET_VAL (`SYNC_IDLE_VAL)
   ) i_lvl_sync (
      .clk      (CLK),
      .rst_n    (RST_N),
      .clk_en   (CLK_EN),
      .async_in ({SYSTEM_RAIL_WAS_ON, CHARGE_ENABLED, INPUT_SUPPLY_IN_WINDOW,
                  INPUT_SUPPLY_VALID, MANUAL_BUTTON_N}),
      .sync_r   (lvl_s)
   );

   // Battery starts absent until seen twice
   pin_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b0)
   ) i_bat_sync (
      .clk      (CLK),
      .rst_n    (RST_N),
      .clk_en   (CLK_EN),
      .async_in (BATTERY_PRESENT),
      .sync_r   (bat_ok)
   );

   wire btn_n   = lvl_s[0];
   wire vin_ok  = lvl_s[1];
   wire vin_win = lvl_s[2];
   wire chg_en  = lvl_s[3];
   wire sys_on  = lvl_s[4];

   wire active = bat_ok | (vin_ok & chg_en);

   reg [7:0] cfg_r;
   reg [2:0] flags_r;
   reg [2:0] irq_st_r, irq_en_r;
   reg [1:0] st_r;
   reg [15:0] ms_div_r;
   reg [15:0] ms_cnt_r;
   reg        wake_done_r;
   reg [31:0] int_cnt_r, rst_cnt_r;

   wire [1:0] wsel = cfg_r[`CFG_WAKE_HI:`CFG_WAKE_LO];
   wire [1:0] rsel = cfg_r[`CFG_RST_HI:`CFG_RST_LO];
   wire [1:0] rec  = cfg_r[`CFG_REC_HI:`CFG_REC_LO];

   reg [15:0] wake_ms, rst_ms;
   always @* begin
      case (wsel)
         2'h0:    wake_ms = `WAKE_MS_0;
         2'h1:    wake_ms = `WAKE_MS_1;
         2'h2:    wake_ms = `WAKE_MS_2;
         default: wake_ms = `WAKE_MS_3;
      endcase
      case (rsel)
         2'h0:    rst_ms = `RST_MS_0;
         2'h1:    rst_ms = `RST_MS_1;
         2'h2:    rst_ms = `RST_MS_2;
         default: rst_ms = `RST_MS_3;
      endcase
   end

   localparam [15:0] MS_LAST = MS_CYCLES - 16'h0001;

   wire       pressed   = ~btn_n & active;
   wire       tick      = (ms_div_r == MS_LAST);
   wire       held_st   = (st_r == ST_HELD);
   wire       wake_hit  = held_st & ~wake_done_r & (ms_cnt_r >= wake_ms);
   wire       rst_qual  = ~cfg_r[`CFG_NEEDS_VIN] | vin_win;
   wire       rst_reach = held_st & (ms_cnt_r >= rst_ms);
   wire       rst_hit   = rst_reach & rst_qual;
   // Hold reached without the input window: flag only, no restart
   wire       rst_fault = rst_reach & ~rst_qual;
   wire       wake_long = (wake_ms >= `WAKE_LONG_MS);
   wire       ctrl_rd   = RD & (ADDR == `ADDR_PB_CTRL);
   wire       cfg_wr    = WR & (ADDR == `ADDR_PB_CFG);
   wire       clr_wr    = WR & (ADDR == `ADDR_IRQ_CLEAR);
   wire       en_wr     = WR & (ADDR == `ADDR_IRQ_ENABLE);
   wire [2:0] flag_set  = {rst_fault, wake_hit & wake_long, wake_hit & ~wake_long};
   wire [2:0] irq_set   = {RECOVERY_VALID, rst_hit, wake_hit};
   wire [7:0] stat_word = {~RESTART_N, RECOVERY_STATE, active, btn_n, st_r, ~INT_PULSE_N};

   // Press tracker: idle, held and timing, waiting for release
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r <= ST_IDLE;
      end else if (CLK_EN) begin
         case (st_r)
            ST_IDLE: begin
               if (pressed) st_r <= ST_HELD;
            end
            ST_HELD: begin
               if (!pressed) begin
                  st_r <= ST_IDLE;
               end else if (rst_hit) begin
                  st_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // A long hold cannot restart twice without a release
               if (btn_n) st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Millisecond prescaler and hold counter, cleared while idle
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ms_div_r    <= 16'h0000;
         ms_cnt_r    <= 16'h0000;
         wake_done_r <= 1'b0;
      end else if (CLK_EN) begin
         if (st_r == ST_IDLE) begin
            ms_div_r    <= 16'h0000;
            ms_cnt_r    <= 16'h0000;
            wake_done_r <= 1'b0;
         end else if (held_st && pressed) begin
            ms_div_r <= tick ? 16'h0000 : ms_div_r + 16'h0001;
            // Saturates so a stuck button never wraps into a new hold
            if (tick && ms_cnt_r != 16'hffff) ms_cnt_r <= ms_cnt_r + 16'h0001;
            if (wake_hit) wake_done_r <= 1'b1;
         end
      end
   end

   // One shared pulse timer; a later event restarts the full width
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_cnt_r   <= 32'h0;
         INT_PULSE_N <= 1'b1;
      end else if (CLK_EN) begin
         if (wake_hit || rst_hit) begin
            int_cnt_r   <= INT_CYC;
            INT_PULSE_N <= 1'b0;
         end else if (int_cnt_r > 32'h1) begin
            int_cnt_r <= int_cnt_r - 32'h1;
         end else begin
            int_cnt_r   <= 32'h0;
            INT_PULSE_N <= 1'b1;
         end
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_cnt_r <= 32'h0;
         RESTART_N <= 1'b1;
      end else if (CLK_EN) begin
         if (rst_hit) begin
            rst_cnt_r <= RST_CYC;
            RESTART_N <= 1'b0;
         end else if (rst_cnt_r > 32'h1) begin
            rst_cnt_r <= rst_cnt_r - 32'h1;
         end else begin
            rst_cnt_r <= 32'h0;
            RESTART_N <= 1'b1;
         end
      end
   end

   // Recovery choice is taken at the restart edge and then held
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RECOVERY_STATE       <= `REC_PREVIOUS;
         RECOVERY_VALID       <= 1'b0;
         SYSTEM_RAIL_REENABLE <= 1'b0;
      end else if (CLK_EN) begin
         RECOVERY_VALID <= rst_hit;
         if (rst_hit) begin
            if (vin_ok) begin
               RECOVERY_STATE       <= `REC_PREVIOUS;
               SYSTEM_RAIL_REENABLE <= 1'b0;
            end else begin
               RECOVERY_STATE       <= (rec == `REC_SHIP) ? `REC_SHIP : `REC_HIZ;
               SYSTEM_RAIL_REENABLE <= ~sys_on & (rec != `REC_SHIP);
            end
         end
      end
   end

   // Set wins over read-clear so no event is lost
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags_r  <= 3'h0;
         irq_st_r <= 3'h0;
      end else if (CLK_EN) begin
         flags_r  <= (ctrl_rd ? 3'h0 : flags_r) | flag_set;
         irq_st_r <= (clr_wr ? (irq_st_r & ~WDATA[2:0]) : irq_st_r) | irq_set;
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_r    <= `CFG_RESET_VAL;
         irq_en_r <= 3'h0;
      end else if (CLK_EN) begin
         if (cfg_wr) cfg_r <= WDATA;
         if (en_wr) irq_en_r <= WDATA[2:0];
      end
   end

   // Read data stand one cycle only, zero otherwise
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else if (CLK_EN) begin
         if (RD) begin
            case (ADDR)
               `ADDR_PB_CTRL:    RDATA <= {5'h00, flags_r};
               `ADDR_PB_CFG:     RDATA <= cfg_r;
               `ADDR_PB_STAT:    RDATA <= stat_word;
               `ADDR_IRQ_STATUS: RDATA <= {5'h00, irq_st_r};
               `ADDR_IRQ_ENABLE: RDATA <= {5'h00, irq_en_r};
               default:          RDATA <= 8'h00;
            endcase
         end else begin
            RDATA <= 8'h00;
         end
      end
   end

   assign IRQ = |(irq_st_r & irq_en_r);
endmodule

// Two-flop synchroniser for asynchronous level inputs
module pin_sync #(
   parameter             WIDTH     = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             clk_en,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_r
);
   reg [WIDTH-1:0] meta_r;

   // Only the second stage may be read outside this module
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
      end else if (clk_en) begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/pb_reset_map.vh */
// Constants for the push-button restart supervisor: register offsets,
// field positions, reset values, hold-time tables and pulse times.
// Included by hdl/pushbutton_reset_controller.v only.
`ifndef PB_RESET_MAP_VH
`define PB_RESET_MAP_VH

// Register offsets (4-bit address)
`define ADDR_PB_CTRL     4'h0
`define ADDR_PB_CFG      4'h1
`define ADDR_PB_STAT     4'h2
`define ADDR_IRQ_STATUS  4'h3
`define ADDR_IRQ_CLEAR   4'h4
`define ADDR_IRQ_ENABLE  4'h5

// Push-button control register fields (read clears flags)
`define CTRL_WAKE_SHORT  0
`define CTRL_WAKE_LONG   1
`define CTRL_RST_FAULT   2

// Configuration register fields
`define CFG_WAKE_LO      0
`define CFG_WAKE_HI      1
`define CFG_RST_LO       2
`define CFG_RST_HI       3
`define CFG_REC_LO       4
`define CFG_REC_HI       5
`define CFG_NEEDS_VIN    6
`define CFG_RESET_VAL    8'h0d

// Recovery target codes
`define REC_SHIP         2'h0
`define REC_HIZ          2'h1
`define REC_ACTIVE       2'h2
`define REC_PREVIOUS     2'h3

// Interrupt status bits
`define IRQ_WAKE         0
`define IRQ_RESTART      1
`define IRQ_RECOVERED    2

// Times
`define INT_PULSE_US     128
`define RESTART_PULSE_MS 400
`define CLK_MHZ          50
`define US_PER_MS        1000

// Synchroniser rest level: button released, supplies valid
`define SYNC_IDLE_VAL    5'h1f

// Hold times in ms by selection code
`define WAKE_MS_0        16'h0032
`define WAKE_MS_1        16'h0064
`define WAKE_MS_2        16'h01f4
`define WAKE_MS_3        16'h03e8
`define RST_MS_0         16'h1388
`define RST_MS_1         16'h2328
`define RST_MS_2         16'h2af8
`define RST_MS_3         16'h3a98
// Long wake flag threshold (ms)
`define WAKE_LONG_MS     16'h03e8

`endif

/* File: dv/pb_reset_monitor.sv */
// Port checker for the push-button supervisor.
// Assumes the bench keeps CLK_EN high.
`timescale 1ns/100ps
`default_nettype none
module pb_reset_monitor #(
   parameter [31:0] INT_CYC = 32'h14,
   parameter [31:0] RST_CYC = 32'h32
) (
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       RD,
   input wire logic       INT_PULSE_N,
   input wire logic       RESTART_N,
   input wire logic       RECOVERY_VALID,
   input wire logic       BUTTON_PULLUP_EN,
   input wire logic       BATTERY_PRESENT,
   input wire logic       INPUT_SUPPLY_VALID,
   input wire logic       SYSTEM_RAIL_REENABLE,
   input wire logic [7:0] RDATA,
   input wire logic [1:0] RECOVERY_STATE
);
   reg [31:0] int_lo_r;
   reg [31:0] rst_lo_r;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Low-time counters, read at the rising edge of each pulse
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         int_lo_r <= 32'h0;
         rst_lo_r <= 32'h0;
      end else begin
         int_lo_r <= INT_PULSE_N ? 32'h0 : int_lo_r + 32'h1;
         rst_lo_r <= RESTART_N ? 32'h0 : rst_lo_r + 32'h1;
      end
   end
   AST_PULLUP: assert property (BUTTON_PULLUP_EN) else $error("pull-up off");
   AST_INT_WIDTH: assert property ($rose(INT_PULSE_N) |-> int_lo_r == INT_CYC) else $error("int width");
   AST_INT_HOLD: assert property ($fell(INT_PULSE_N) |-> !INT_PULSE_N [*8]) else $error("int glitch");
   AST_RST_WIDTH: assert property ($rose(RESTART_N) |-> rst_lo_r == RST_CYC) else $error("restart width");
   AST_RST_ONCE: assert property ($rose(RESTART_N) |=> RESTART_N [*8]) else $error("restart repeat");
   AST_GATED: assert property ($fell(INT_PULSE_N) |-> BATTERY_PRESENT || INPUT_SUPPLY_VALID) else $error("ungated");
   AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata not idle");
   AST_RESUME: assert property (RECOVERY_VALID && INPUT_SUPPLY_VALID |-> RECOVERY_STATE == 2'h3) else $error("resume");
   AST_NO_REEN: assert property (RECOVERY_VALID && INPUT_SUPPLY_VALID |=> !SYSTEM_RAIL_REENABLE) else $error("reen");
   AST_REC_RST: assert property (RECOVERY_VALID |-> !RESTART_N) else $error("recovery w/o restart");
   AST_RST_INT: assert property ($fell(RESTART_N) |-> !INT_PULSE_N) else $error("restart without int");
endmodule
bind pushbutton_reset_controller pb_reset_monitor #(.INT_CYC(INT_CYC), .RST_CYC(RST_CYC)) i_mon (
   .CLK(CLK), .RST_N(RST_N), .RD(RD), .INT_PULSE_N(INT_PULSE_N), .RESTART_N(RESTART_N),
   .RECOVERY_VALID(RECOVERY_VALID), .BUTTON_PULLUP_EN(BUTTON_PULLUP_EN), .BATTERY_PRESENT(BATTERY_PRESENT),
   .INPUT_SUPPLY_VALID(INPUT_SUPPLY_VALID), .SYSTEM_RAIL_REENABLE(SYSTEM_RAIL_REENABLE), .RDATA(RDATA),
   .RECOVERY_STATE(RECOVERY_STATE));
`default_nettype wire

/* File: dv/pb_button_model.sv */
// Push-button switch to ground on a pulled-up line.
// Assumes the bench presses only while supplies are stable.
`timescale 1ns/100ps
`default_nettype none
module pb_button_model (
   input  wire logic press,
   input  wire logic pull_en,
   output wire logic btn_n
);
   // Released line rests at the pull-up level
   assign btn_n = press ? 1'b0 : pull_en;
endmodule
`default_nettype wire

/* File: dv/test_pushbutton_reset_controller.sv */
// Self-checking bench for the push-button supervisor.
// Assumes shortened counts: 2 cycles per ms, 20-cycle int, 50-cycle restart.
`timescale 1ns/100ps
`default_nettype none
module test_pushbutton_reset_controller;
   logic       clk = 0, rst_n = 0, battery_rail = 1, input_supply = 0, win = 0, chg = 0, was_on = 0, wr = 0, rd = 0, press = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   wire        btn_n, pull_en, int_n, rst_o_n, rec_v, reen, irq;
   wire [1:0]  rec;
   wire [7:0]  rdata;
   int         miscompares = 0, n_tests = 0, n_int = 0, n_rst = 0, rst_lo = 0, i, j, k;
   always #10 clk = ~clk;
   always @(negedge int_n) n_int++;
   always @(negedge rst_o_n) n_rst++;
   always @(posedge clk) if (rst_o_n === 1'b0) rst_lo++;
   pb_button_model i_btn (.press(press), .pull_en(pull_en), .btn_n(btn_n));
   pushbutton_reset_controller #(.MS_CYCLES(2), .INT_CYC(32'h14), .RST_CYC(32'h32)) i_dut (
      .CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .MANUAL_BUTTON_N(btn_n), .BUTTON_PULLUP_EN(pull_en),
      .BATTERY_PRESENT(battery_rail), .INPUT_SUPPLY_VALID(input_supply), .INPUT_SUPPLY_IN_WINDOW(win), .CHARGE_ENABLED(chg),
      .SYSTEM_RAIL_WAS_ON(was_on), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .INT_PULSE_N(int_n), .RESTART_N(rst_o_n), .RECOVERY_STATE(rec), .RECOVERY_VALID(rec_v),
      .SYSTEM_RAIL_REENABLE(reen), .IRQ(irq));
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %0h, seen %0h", s, e, g);
      end
   endtask
   task automatic wrr(logic [3:0] a, logic [7:0] v);
      @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk); wr <= 1'b0;
   endtask
   task automatic rdc(string s, logic [3:0] a, logic [7:0] e);
      @(posedge clk); addr <= a; rd <= 1'b1;
      @(posedge clk); rd <= 1'b0;
      #1 chk(s, e, rdata);
   endtask
   // Hold the button n cycles, then let the release settle
   task automatic push(int n);
      @(posedge clk); press <= 1'b1;
      repeat (n) @(posedge clk);
      press <= 1'b0;
      repeat (30) @(posedge clk);
   endtask
   task automatic irq_is(logic [3:0] a, logic [7:0] v, logic e);
      wrr(a, v);
      @(posedge clk);
      #1 chk("irq", e, irq);
   endtask
   task automatic t_regs;
      rdc("cfg reset", 4'h1, 8'h0d);
      rdc("unmapped", 4'h9, 8'h00);
      wrr(4'h1, 8'h10);
      rdc("cfg", 4'h1, 8'h10);
   endtask
   task automatic t_wake;
      i = n_int;
      wrr(4'h5, 8'h01);
      push(300);
      chk("wake int", i + 1, n_int);
      irq_is(4'h5, 8'h00, 1'b0);
      irq_is(4'h5, 8'h01, 1'b1);
      irq_is(4'h4, 8'h01, 1'b0);
      rdc("flags", 4'h0, 8'h01);
      rdc("flags cleared", 4'h0, 8'h00);
      wrr(4'h1, 8'h13);
      push(2300);
      rdc("long flag", 4'h0, 8'h02);
      wrr(4'h1, 8'h10);
   endtask
   task automatic t_gate;
      i = n_int;
      battery_rail <= 1'b0;
      repeat (10) @(posedge clk);
      push(300);
      chk("gated int", i, n_int);
      battery_rail <= 1'b1;
   endtask
   task automatic t_restart;
      i = n_int; j = n_rst; k = rst_lo;
      push(10300);
      chk("restart count", j + 1, n_rst);
      chk("restart width", k + 50, rst_lo);
      chk("restart int", i + 2, n_int);
      chk("recovery", 2'h1, rec);
      chk("reenable", 1'b1, reen);
      rdc("flags", 4'h0, 8'h01);
      rdc("stat", 4'h2, 8'h38);
      rdc("irq status", 4'h3, 8'h07);
      wrr(4'h4, 8'h07);
   endtask
   task automatic t_fault;
      wrr(4'h1, 8'h50);
      j = n_rst;
      push(10300);
      chk("no restart", j, n_rst);
      rdc("fault flag", 4'h0, 8'h05);
   endtask
   task automatic t_ship;
      wrr(4'h1, 8'h00);
      j = n_rst;
      push(10300);
      chk("rearm", j + 1, n_rst);
      chk("ship", 2'h0, rec);
      chk("ship reenable", 1'b0, reen);
   endtask
   task automatic t_prev;
      wrr(4'h1, 8'h10);
      input_supply <= 1'b1; chg <= 1'b1; win <= 1'b1;
      repeat (10) @(posedge clk);
      push(10300);
      chk("resume", 2'h3, rec);
      chk("no reenable", 1'b0, reen);
   endtask
   task automatic test_done;
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Tests take about 45k cycles
   initial begin
      #1500000;
      miscompares++;
      test_done;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_regs; t_wake; t_gate; t_restart; t_fault; t_ship; t_prev;
      test_done;
   end
endmodule
`default_nettype wire
